// [hw/clkgen_pkg.sv]
/*
 * Constants, register map and shared types of the DSP clock generator.
 * Assumes a single 250 MHz system clock that times every derived rate.
 */
`default_nettype none
package clkgen_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] PLL_CSR_ADDR   = 16'h1C80;
    localparam logic [15:0] CORE_SEL_ADDR  = 16'h1C82;
    localparam logic [15:0] MULT_ADDR      = 16'h1C88;
    localparam logic [15:0] PREDIV_ADDR    = 16'h1C8A;
    localparam logic [15:0] FAST_DIV_ADDR  = 16'h1C8C;
    localparam logic [15:0] SLOW_DIV_ADDR  = 16'h1C8E;
    localparam logic [15:0] MEMIF_DIV_ADDR = 16'h1C90;
    localparam logic [15:0] CLK_MODE_ADDR  = 16'h8C00;
    // ------------------------------------------------------------
    // Field positions of the control / status register
    // ------------------------------------------------------------
    localparam int CSR_PLL_ENABLE_BIT_BIT     = 0;
    localparam int CSR_OSC_SLEEP_BIT = 2;
    localparam int CSR_LOOP_RST_BIT  = 3;
    localparam int CSR_LOCK_BIT      = 5;
    localparam int CSR_STABLE_BIT    = 6;
    // ------------------------------------------------------------
    // Reset values and divider codes
    // ------------------------------------------------------------
    localparam logic [3:0] CORE_SEL_RESET = 4'hB;
    localparam logic [3:0] MULT_RESET     = 4'h2;
    localparam logic [3:0] MULT_MIN       = 4'h2;
    localparam logic [4:0] PREDIV_RESET   = 5'h00;
    localparam logic [1:0] POST_DIV_BY1   = 2'h0;
    localparam logic [1:0] POST_DIV_BY2   = 2'h1;
    localparam logic [1:0] POST_DIV_BY4   = 2'h3;
    localparam logic [1:0] POST_DIV_RESET = POST_DIV_BY4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ        = 250;
    localparam int OSC_STABLE_CYCLES  = 41032;
    localparam int LOCK_TIME_NS       = 2000;
    localparam int LOCK_CYCLES        = (LOCK_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OSC_INIT      = 2'b00,
        OSC_STABILIZE = 2'b01,
        OSC_RUN       = 2'b11,
        OSC_SLEEP     = 2'b10
    } osc_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
endpackage
`default_nettype wire

// [hw/dsp_clock_generator.sv]
/*
 * Clock generator: source select, pre-divider and multiplier, oscillator
 * sleep and stabilization, three post-dividers giving group clock enables.
 * Assumes all derived clocks are one-cycle enables of i_sys_clk and that
 * pins arrive asynchronously; the register port is a same-clock master.
 */
// The address-and-strobe port and the address map are this design's own decisions.
`default_nettype none
module dsp_clock_generator #(
    parameter int OSC_STABLE_COUNT = clkgen_pkg::OSC_STABLE_CYCLES
) (
    input  wire logic                 i_sys_clk,            // System clock
    input  wire logic                 i_rst,                // Async reset, high
    input  wire clkgen_pkg::reg_req_t i_req,                // Register request
    output logic [15:0]               o_rd_data,            // Read data, next cycle
    input  wire logic                 i_strap_pin_four,     // Source strap pin
    input  wire logic                 i_ext_clock_pin,      // External clock pin
    input  wire logic                 i_clockgen_idle_flag, // Idle handshake
    input  wire logic                 i_test_mode,          // Test mode level
    output logic                      o_osc_enable,         // Oscillator powered
    output logic                      o_core_clk_en,        // Core clock enable
    output logic                      o_fast_clk_en,        // Fast group enable
    output logic                      o_slow_clk_en,        // Slow group enable
    output logic                      o_memif_clk_en,       // Memory group enable
    output logic                      o_program_run,        // Program may run
    output logic                      o_input_source        // Source select bit
);
    import clkgen_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic        strap_meta_reg, strap_sync_reg;
    logic        ext_meta_reg, ext_sync_reg, ext_prev_reg;
    logic [1:0]  init_cnt_reg;
    logic        source_sel_reg;
    osc_state_t  osc_state_reg;
    logic [15:0] stab_cnt_reg;
    logic        pll_en_reg, loop_rst_reg, osc_sleep_reg;
    logic [3:0]  core_sel_reg, mult_reg, mult_eff;
    logic [4:0]  prediv_reg, prediv_cnt_reg;
    logic [1:0]  post_div_reg [3];
    logic [1:0]  grp_cnt_reg [3];
    logic [1:0]  grp_lim_reg [3];
    logic [2:0]  grp_pulse_reg;
    logic [4:0]  mult_acc_reg;
    logic [5:0]  acc_sum;
    logic        mode_pll_reg;
    logic [15:0] lock_cnt_reg;
    logic        lock_reg, stable_bit;
    logic        ref_tick, pll_ref_tick, pll_tick, core_tick, retune;
    logic        core_en_reg, osc_en_reg, run_reg;
    logic [15:0] rd_data_reg;

    localparam logic [15:0] STAB_LOAD = 16'(OSC_STABLE_COUNT - 1);
    localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);
    localparam logic [1:0]  INIT_LAST = 2'h2;

    // ------------------------------------------------------------
    // Pin synchronizers
    // ------------------------------------------------------------
    // Two flops before any reader; edge detect only looks past them
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
            ext_meta_reg   <= 1'b0;
            ext_sync_reg   <= 1'b0;
            ext_prev_reg   <= 1'b0;
        end
        else
        begin
            strap_meta_reg <= i_strap_pin_four;
            strap_sync_reg <= strap_meta_reg;
            ext_meta_reg   <= i_ext_clock_pin;
            ext_sync_reg   <= ext_meta_reg;
            ext_prev_reg   <= ext_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Strap capture and source select
    // ------------------------------------------------------------
    // Strap is caught once the synchronizer has filled after release
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            init_cnt_reg   <= 2'h0;
            source_sel_reg <= 1'b0;
        end
        else if (osc_state_reg == OSC_INIT)
        begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
            if (init_cnt_reg == INIT_LAST)
                source_sel_reg <= strap_sync_reg;
        end
        else if (i_req.wr && i_req.addr == CLK_MODE_ADDR)
            source_sel_reg <= i_req.wdata[0];
    end

    // ------------------------------------------------------------
    // Oscillator power and stabilization
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            osc_state_reg <= OSC_INIT;
            stab_cnt_reg  <= 16'h0000;
        end
        else
        begin
            unique case (osc_state_reg)
                OSC_INIT:
                    if (init_cnt_reg == INIT_LAST)
                    begin
                        // External strap disables the reset count
                        osc_state_reg <= strap_sync_reg ? OSC_RUN
                                                        : OSC_STABILIZE;
                        stab_cnt_reg  <= STAB_LOAD;
                    end
                OSC_STABILIZE:
                    if (stab_cnt_reg == 16'h0000)
                        osc_state_reg <= OSC_RUN;
                    else
                        stab_cnt_reg <= stab_cnt_reg - 16'h0001;
                OSC_RUN:
                    if (osc_sleep_reg
                        && (source_sel_reg || i_clockgen_idle_flag))
                        osc_state_reg <= OSC_SLEEP;
                OSC_SLEEP:
                    if (!osc_sleep_reg)
                    begin
                        osc_state_reg <= OSC_STABILIZE;
                        stab_cnt_reg  <= STAB_LOAD;
                    end
            endcase
        end
    end

    assign stable_bit = (osc_state_reg == OSC_RUN) || i_test_mode;

    // ------------------------------------------------------------
    // Reference tick, pre-divider and multiplier
    // ------------------------------------------------------------
    // Oscillator ticks every cycle while stabilizing or running; pin ticks on rising edges
    always_comb
    begin
        if (source_sel_reg)
            ref_tick = ext_sync_reg && !ext_prev_reg;
        else
            ref_tick = osc_state_reg == OSC_STABILIZE
                       || osc_state_reg == OSC_RUN;
        pll_ref_tick = ref_tick && prediv_cnt_reg == prediv_reg;
        mult_eff     = mult_reg < MULT_MIN ? MULT_MIN : mult_reg;
        pll_tick     = mult_acc_reg != 5'h00;
        acc_sum      = {1'b0, mult_acc_reg} - {5'h00, pll_tick}
                       + (pll_ref_tick ? {2'h0, mult_eff} : 6'h00);
        // Test sources just pass the raw input clock
        if (core_sel_reg != CORE_SEL_RESET)
            core_tick = ref_tick;
        else
            core_tick = mode_pll_reg ? pll_tick : ref_tick;
        retune = i_req.wr && (i_req.addr == MULT_ADDR
                              || i_req.addr == PREDIV_ADDR);
    end

    // Multiplier spreads M pulses per reference; one per cycle at most
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prediv_cnt_reg <= 5'h00;
            mult_acc_reg   <= 5'h00;
        end
        else if (loop_rst_reg)
        begin
            prediv_cnt_reg <= 5'h00;
            mult_acc_reg   <= 5'h00;
        end
        else
        begin
            if (ref_tick)
                prediv_cnt_reg <= pll_ref_tick ? 5'h00
                                               : prediv_cnt_reg + 5'h01;
            mult_acc_reg <= acc_sum[5] ? 5'h1F : acc_sum[4:0];
        end
    end

    // Lock model: loop reset or new ratio drops lock until settle time ends
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lock_cnt_reg <= 16'h0000;
            lock_reg     <= 1'b0;
        end
        else if (loop_rst_reg || retune)
        begin
            lock_cnt_reg <= 16'h0000;
            lock_reg     <= 1'b0;
        end
        else if (lock_cnt_reg == LOCK_LAST)
            lock_reg <= 1'b1;
        else
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    end

    // Mode switches only with the multiplier drained at an input edge,
    // so no pulse from either path is cut short
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            mode_pll_reg <= 1'b0;
        else if (ref_tick && !pll_tick)
            mode_pll_reg <= pll_en_reg;
    end

    // ------------------------------------------------------------
    // Post-dividers for the three groups
    // ------------------------------------------------------------
    // New ratio is taken only at a wrap, keeping every period whole
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int g = 0; g < 3; g++)
            begin
                grp_cnt_reg[g] <= 2'h0;
                grp_lim_reg[g] <= POST_DIV_RESET;
            end
            grp_pulse_reg <= 3'h0;
        end
        else
        begin
            for (int g = 0; g < 3; g++)
            begin
                grp_pulse_reg[g] <= core_tick
                                    && grp_cnt_reg[g] == grp_lim_reg[g];
                if (core_tick && grp_cnt_reg[g] == grp_lim_reg[g])
                begin
                    grp_cnt_reg[g] <= 2'h0;
                    grp_lim_reg[g] <= (post_div_reg[g] == POST_DIV_BY1)
                                      ? POST_DIV_BY1
                                      : (post_div_reg[g] == POST_DIV_BY2)
                                      ? POST_DIV_BY2 : POST_DIV_BY4;
                end
                else if (core_tick)
                    grp_cnt_reg[g] <= grp_cnt_reg[g] + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pll_en_reg    <= 1'b0;
            loop_rst_reg  <= 1'b0;
            osc_sleep_reg <= 1'b0;
            core_sel_reg  <= CORE_SEL_RESET;
            mult_reg      <= MULT_RESET;
            prediv_reg    <= PREDIV_RESET;
            for (int g = 0; g < 3; g++)
                post_div_reg[g] <= POST_DIV_RESET;
        end
        else if (i_req.wr)
        begin
            unique case (i_req.addr)
                PLL_CSR_ADDR:
                begin
                    pll_en_reg    <= i_req.wdata[CSR_PLL_ENABLE_BIT_BIT];
                    loop_rst_reg  <= i_req.wdata[CSR_LOOP_RST_BIT];
                    osc_sleep_reg <= i_req.wdata[CSR_OSC_SLEEP_BIT];
                end
                CORE_SEL_ADDR:  core_sel_reg    <= i_req.wdata[3:0];
                MULT_ADDR:      mult_reg        <= i_req.wdata[3:0];
                PREDIV_ADDR:    prediv_reg      <= i_req.wdata[4:0];
                FAST_DIV_ADDR:  post_div_reg[0] <= i_req.wdata[1:0];
                SLOW_DIV_ADDR:  post_div_reg[1] <= i_req.wdata[1:0];
                MEMIF_DIV_ADDR: post_div_reg[2] <= i_req.wdata[1:0];
                default:        ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads and registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
            rd_data_reg <= 16'h0000;
        else if (!i_req.rd)
            rd_data_reg <= 16'h0000;
        else
        begin
            unique case (i_req.addr)
                PLL_CSR_ADDR:
                    rd_data_reg <= 16'(pll_en_reg) << CSR_PLL_ENABLE_BIT_BIT
                        | 16'(osc_sleep_reg) << CSR_OSC_SLEEP_BIT
                        | 16'(loop_rst_reg) << CSR_LOOP_RST_BIT
                        | 16'(lock_reg) << CSR_LOCK_BIT
                        | 16'(stable_bit) << CSR_STABLE_BIT;
                CORE_SEL_ADDR:  rd_data_reg <= {12'h000, core_sel_reg};
                MULT_ADDR:      rd_data_reg <= {12'h000, mult_reg};
                PREDIV_ADDR:    rd_data_reg <= {11'h000, prediv_reg};
                FAST_DIV_ADDR:  rd_data_reg <= {14'h0000, post_div_reg[0]};
                SLOW_DIV_ADDR:  rd_data_reg <= {14'h0000, post_div_reg[1]};
                MEMIF_DIV_ADDR: rd_data_reg <= {14'h0000, post_div_reg[2]};
                CLK_MODE_ADDR:  rd_data_reg <= {15'h0000, source_sel_reg};
                default:        rd_data_reg <= 16'h0000;
            endcase
        end
    end

    // Program runs off the pin clock even while the oscillator sleeps
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            core_en_reg <= 1'b0;
            osc_en_reg  <= 1'b1;
            run_reg     <= 1'b0;
        end
        else
        begin
            core_en_reg <= core_tick;
            osc_en_reg  <= osc_state_reg != OSC_SLEEP;
            run_reg     <= osc_state_reg != OSC_INIT
                           && (source_sel_reg
                               || osc_state_reg == OSC_RUN);
        end
    end

    assign o_rd_data      = rd_data_reg;
    assign o_core_clk_en  = core_en_reg;
    assign o_fast_clk_en  = grp_pulse_reg[0];
    assign o_slow_clk_en  = grp_pulse_reg[1];
    assign o_memif_clk_en = grp_pulse_reg[2];
    assign o_osc_enable   = osc_en_reg;
    assign o_program_run  = run_reg;
    assign o_input_source = source_sel_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    a_strap_capture: assert property (
        osc_state_reg == OSC_INIT && init_cnt_reg == INIT_LAST
        |=> source_sel_reg == $past(strap_sync_reg))
        else $error("source select not taken from strap");
    a_bypass_path: assert property (
        !mode_pll_reg && core_sel_reg == CORE_SEL_RESET
        |=> o_core_clk_en == $past(ref_tick))
        else $error("bypass core clock does not follow input");
    a_prediv_wrap: assert property (
        pll_ref_tick && !loop_rst_reg |=> prediv_cnt_reg == 5'h00)
        else $error("pre-divider did not wrap");
    a_sleep_waits: assert property (
        osc_state_reg == OSC_RUN && !source_sel_reg
        && !i_clockgen_idle_flag |=> osc_state_reg != OSC_SLEEP)
        else $error("oscillator slept before idle");
    a_sleep_now: assert property (
        osc_state_reg == OSC_RUN && source_sel_reg && osc_sleep_reg
        |=> osc_state_reg == OSC_SLEEP ##1 !o_osc_enable)
        else $error("oscillator did not sleep at once");
    a_stab_load: assert property (
        $rose(osc_state_reg == OSC_STABILIZE) |-> stab_cnt_reg == STAB_LOAD)
        else $error("stabilization count not loaded");
    a_run_held: assert property (
        !source_sel_reg && osc_state_reg != OSC_RUN |=> !o_program_run)
        else $error("program ran before oscillator stable");
    a_run_resume: assert property (
        osc_state_reg == OSC_STABILIZE && stab_cnt_reg == 16'h0000
        |=> ##1 o_program_run)
        else $error("program did not resume after count");
    a_stable_status: assert property (
        osc_state_reg == OSC_STABILIZE && !i_test_mode |-> !stable_bit)
        else $error("stable reported while counting");
    a_lock_drop: assert property (
        loop_rst_reg |=> !lock_reg)
        else $error("lock held through loop reset");
    a_fast_cause: assert property (
        o_fast_clk_en |-> $past(core_tick))
        else $error("fast pulse without core tick");

    c_pll_mode: cover property (mode_pll_reg && o_core_clk_en);
    c_osc_wake: cover property (
        osc_state_reg == OSC_SLEEP ##1 osc_state_reg == OSC_STABILIZE);
    c_fast_div1: cover property (
        grp_lim_reg[0] == POST_DIV_BY1 && o_fast_clk_en);
    c_locked: cover property ($rose(lock_reg));
endmodule
`default_nettype wire

// [testbench/dsp_clock_generator_bench.sv]
/*
 * Self-checking bench of the clock generator: register reads, post
 * dividers, oscillator sleep and wake, strap select, PLL ratio counts.
 * Assumes the package and port list as delivered, short stable count.
 */
`default_nettype none
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end end
`define WT(c, n) for (k = 0; k < (n) && !(c); k++) @(posedge clk);
module dsp_clock_generator_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import clkgen_pkg::*;
    logic clk, rst, strap, pin, idle, test, osc_en, core_en, fast_en;
    logic slow_en, mem_en, prun, src, rd_d, pin_d, pin_on;
    logic [2:0]  ph;
    reg_req_t    req;
    logic [15:0] rdata, e, m, expq[$], mskq[$];
    logic [31:0] rng;
    int          error_cnt, n_compared, k, mul, f, c[5], s[5];
    logic [15:0] ta[8] = '{CORE_SEL_ADDR, MULT_ADDR, PREDIV_ADDR,
        FAST_DIV_ADDR, SLOW_DIV_ADDR, MEMIF_DIV_ADDR, CLK_MODE_ADDR, 16'h1C84};
    logic [15:0] te[8] = '{16'h000B, 16'h0002, 16'h0000, 16'h0003,
        16'h0003, 16'h0003, 16'h0000, 16'h0000};

    dsp_clock_generator #(.OSC_STABLE_COUNT(16)) uut (
        .i_sys_clk(clk), .i_rst(rst), .i_req(req), .o_rd_data(rdata),
        .i_strap_pin_four(strap), .i_ext_clock_pin(pin),
        .i_clockgen_idle_flag(idle), .i_test_mode(test),
        .o_osc_enable(osc_en), .o_core_clk_en(core_en),
        .o_fast_clk_en(fast_en), .o_slow_clk_en(slow_en),
        .o_memif_clk_en(mem_en), .o_program_run(prun), .o_input_source(src));

    // ------------------------------------------------------------
    // Clock, pin source, watcher
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pin period of 8 cycles keeps the two-flop sync honest
    always @(posedge clk)
    begin
        ph <= ph + 3'h1;
        pin <= pin_on & ph[2];
        pin_d <= pin;
        rd_d <= req.rd;
        c <= '{c[0] + core_en, c[1] + fast_en, c[2] + slow_en,
               c[3] + mem_en, c[4] + (pin & !pin_d)};
        if (rd_d)
        begin
            e = expq.pop_front();
            m = mskq.pop_front();
            `CMP("read data", e, rdata & m)
        end
    end

    // ------------------------------------------------------------
    // Bus tasks and helpers
    // ------------------------------------------------------------
    task wr(input logic [15:0] a, d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task rd(input logic [15:0] a, x, mk);
        expq.push_back(x);
        mskq.push_back(mk);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
    endtask
    task near(input string n, input int g, x, tol);
        `CMP(n, x, ((g >= x - tol && g <= x + tol) ? x : g))
    endtask
    // Xorshift step for the random stimulus
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task window(input int n);
        s = c;
        repeat (n) @(posedge clk);
    endtask
    task reset_dut(input logic st);
        strap <= st;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        results;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, strap, idle, test, pin_on, ph, pin, pin_d} = 10'h200;
        req = '0;
        rng = 32'h00007A4A;
        reset_dut(1'b0);
        `CMP("source", 1'b0, src)
        `CMP("run early", 1'b0, prun)
        rd(PLL_CSR_ADDR, 16'h0000, 16'h0040);
        for (int i = 0; i < 8; i++)
            rd(ta[i], te[i], 16'hFFFF);
        `WT(prun === 1'b1, 40)
        `CMP("run", 1'b1, prun)
        rd(PLL_CSR_ADDR, 16'h0040, 16'h0041);
        window(40);
        `CMP("core", 40, c[0] - s[0])
        for (int g = 1; g < 4; g++)
            `CMP("group /4", 10, c[g] - s[g])
        // Fast at /2 stays under its ceiling; the others never outrun it
        rng = xs(rng);
        wr(FAST_DIV_ADDR, 16'h0001);
        wr(SLOW_DIV_ADDR, {14'h0, rng[0], 1'b1});
        wr(MEMIF_DIV_ADDR, {14'h0, 1'b1, rng[1]});
        repeat (8) @(posedge clk);
        window(40);
        `CMP("fast", 20, c[1] - s[1])
        `CMP("slow", rng[0] ? 10 : 20, c[2] - s[2])
        `CMP("memif", 10, c[3] - s[3])
        wr(PLL_CSR_ADDR, 16'h0004);
        repeat (6) @(posedge clk);
        `CMP("osc held", 1'b1, osc_en)
        idle <= 1'b1;
        `WT(osc_en === 1'b0, 4)
        `CMP("osc off", 1'b0, osc_en)
        idle <= 1'b0;
        wr(PLL_CSR_ADDR, 16'h0000);
        rd(PLL_CSR_ADDR, 16'h0000, 16'h0040);
        `WT(prun === 1'b1 && osc_en === 1'b1, 40)
        `CMP("resume", 1'b1, prun & osc_en)
        reset_dut(1'b1);
        `CMP("source pin", 1'b1, src)
        `CMP("run pin", 1'b1, prun)
        pin_on <= 1'b1;
        // Slow pin clock lets fast run at /1; wait out the old /4 period
        wr(FAST_DIV_ADDR, 16'h0000);
        repeat (40) @(posedge clk);
        window(64);
        near("bypass core", c[0] - s[0], 8, 1);
        `CMP("fast /1", c[0] - s[0], c[1] - s[1])
        // Ratio keeps reference and loop output inside their ranges
        rng = xs(rng);
        mul = 5 + int'(rng[5:4]) % 3;
        f = rng[8] ? 2 : 1;
        wr(PLL_CSR_ADDR, 16'h0008);
        wr(FAST_DIV_ADDR, 16'h0001);
        wr(MULT_ADDR, 16'(mul));
        wr(PREDIV_ADDR, 16'(f - 1));
        rd(PLL_CSR_ADDR, 16'h0000, 16'h0020);
        repeat (250) @(posedge clk);
        wr(PLL_CSR_ADDR, 16'h0000);
        repeat (520) @(posedge clk);
        rd(PLL_CSR_ADDR, 16'h0020, 16'h0020);
        wr(PLL_CSR_ADDR, 16'h0001);
        repeat (20) @(posedge clk);
        window(64);
        near("pll core", c[0] - s[0], mul * 8 / f, 2 * mul);
        near("pll fast", c[1] - s[1], (c[0] - s[0]) / 2, 1);
        wr(PLL_CSR_ADDR, 16'h0005);
        `WT(osc_en === 1'b0, 3)
        `CMP("osc off pin", 1'b0, osc_en)
        test <= 1'b1;
        rd(PLL_CSR_ADDR, 16'h0040, 16'h0040);
        test <= 1'b0;
        rd(PLL_CSR_ADDR, 16'h0000, 16'h0040);
        repeat (4) @(posedge clk);
        results;
    end
endmodule
`default_nettype wire
